// File: rtl/panel_seq_pkg.sv
// How it works
// - Output buttons step their output's video input
// - Audio button steps audio source likewise
// - Two-input variant: buttons pick USB-C, HDMI
// - Audio output follows selected source's audio
// - Buttons one and audio within 100ms toggle lock
// - Lock change blinks LEDs four times
// - Locked presses only blink LEDs three quick
// - Audio held 5s starts LED blinking
// - Release, three presses in 3s: dynamic addressing
// - Keep holding past 5s for reset path
// - Audio held 10s blinks LEDs faster
// - Then three presses: defaults, dark, reboot
// - Defaults select dynamic addressing
// - Lights-off keeps every LED unlit
// - Chosen port's status LED blinks once
`default_nettype none
package panel_seq_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 40;
  localparam int TICK_NS         = 1000000;
  localparam int TICK_CYCLES_DEF = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEBOUNCE_MS     = 20;
  localparam int LOCK_WIN_MS     = 100;
  localparam int ADDR_HOLD_MS    = 5000;
  localparam int RESET_HOLD_MS   = 10000;
  localparam int TRIPLE_WIN_MS   = 3000;
  localparam int TAP_COUNT       = 3;
  localparam int LOCK_BLINKS     = 4;
  localparam int LOCKED_BLINKS   = 3;
  localparam int BLINK_HALF_MS   = 250;
  localparam int QUICK_HALF_MS   = 60;
  localparam int SLOW_HALF_MS    = 400;
  localparam int FAST_HALF_MS    = 100;
  localparam int DARK_MS         = 1000;
  localparam int PORT_BLINK_MS   = 300;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_SEL    = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_EVENT  = 4'hc;
  localparam int CTRL_LIGHTS_OFF = 0;
  localparam int CTRL_DHCP       = 1;
  localparam int CTRL_LOCK       = 2;
  localparam int EV_DHCP         = 0;
  localparam int EV_FACTORY      = 1;
  localparam int EV_LOCK         = 2;
  localparam int SEL_W           = 2;
  localparam logic CTRL_DHCP_RST = 1'b1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [2:0] {S_IDLE, S_HOLD, S_ADDR_HELD, S_RST_HELD, S_ADDR_TAP, S_RST_TAP} seq_state_t;
endpackage
`default_nettype wire

// File: rtl/front_panel_button_sequencer.sv
`default_nettype none
module front_panel_button_sequencer
  import panel_seq_pkg::*;
#(
  parameter int NUM_INPUTS  = 4,
  parameter bit TWO_INPUT   = 1'b0,
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              clk_en,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  // Panel buttons: 0..2 output selects, 3 audio
  input  wire logic [3:0]        btn_raw,
  // Crosspoint selections
  output logic [SEL_W-1:0]       sel_out_one,
  output logic [SEL_W-1:0]       sel_out_two,
  output logic [SEL_W-1:0]       sel_out_three,
  output logic [SEL_W-1:0]       audio_src,
  // Configuration store
  output logic                   dhcp_enable,
  output logic                   reboot_req,
  // LEDs
  output logic                   front_led_force,
  output logic                   front_led_lit,
  output logic [3:0]             port_led_blink
);
  initial begin
    if (NUM_INPUTS < 2 || NUM_INPUTS > (1 << SEL_W)) $error("NUM_INPUTS out of range");
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) $error("TICK_CYCLES out of range");
  end

  // Next input in cyclic order
  function automatic logic [SEL_W-1:0] adv(input logic [SEL_W-1:0] cur);
    adv = (cur == SEL_W'(NUM_INPUTS - 1)) ? '0 : cur + 1'b1;
  endfunction

  // ****************************************
  // Millisecond tick
  // ****************************************
  logic [15:0] tick_cnt_ff;
  logic        tick;
  assign tick = clk_en && (tick_cnt_ff == 16'(TICK_CYCLES - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tick_cnt_ff <= 16'h0000;
    else if (clk_en) tick_cnt_ff <= tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
  end

  // ****************************************
  // Button sync and debounce
  // ****************************************
  logic [3:0] sync1_ff, sync2_ff, stable_ff, press;
  logic [4:0] deb_ms_ff [4];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else if (clk_en) begin
      sync1_ff <= btn_raw;
      sync2_ff <= sync1_ff;
    end
  end
  // Accept a level only after it holds for the debounce time
  always_comb begin
    for (int i = 0; i < 4; i++)
      press[i] = tick && sync2_ff[i] && !stable_ff[i] && (deb_ms_ff[i] == 5'(DEBOUNCE_MS - 1));
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stable_ff <= 4'h0;
      for (int i = 0; i < 4; i++) deb_ms_ff[i] <= 5'h00;
    end else if (clk_en) begin
      for (int i = 0; i < 4; i++) begin
        if (sync2_ff[i] == stable_ff[i]) deb_ms_ff[i] <= 5'h00;
        else if (tick) begin
          if (deb_ms_ff[i] == 5'(DEBOUNCE_MS - 1)) begin
            stable_ff[i] <= sync2_ff[i];
            deb_ms_ff[i] <= 5'h00;
          end else deb_ms_ff[i] <= deb_ms_ff[i] + 5'h01;
        end
      end
    end
  end

  // ****************************************
  // Hold and triple-press sequence
  // ****************************************
  seq_state_t  state_ff;
  logic [13:0] seq_ms_ff;
  logic [1:0]  taps_ff;
  logic        lock_ff, tap_state, tap_done, dhcp_go, factory_go, seq_blink, seq_fast, timeout;
  assign tap_state  = (state_ff == S_ADDR_TAP) || (state_ff == S_RST_TAP);
  assign tap_done   = tap_state && press[3] && (taps_ff == 2'(TAP_COUNT - 1));
  assign dhcp_go    = tap_done && (state_ff == S_ADDR_TAP);
  assign factory_go = tap_done && (state_ff == S_RST_TAP);
  assign timeout    = tap_state && !tap_done && tick && (seq_ms_ff == 14'(TRIPLE_WIN_MS - 1));
  assign seq_fast   = (state_ff == S_RST_HELD) || (state_ff == S_RST_TAP);
  assign seq_blink  = seq_fast || (state_ff == S_ADDR_HELD) || (state_ff == S_ADDR_TAP);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff  <= S_IDLE;
      seq_ms_ff <= 14'h0000;
      taps_ff   <= 2'h0;
    end else if (clk_en) begin
      case (state_ff)
        S_IDLE: begin
          seq_ms_ff <= 14'h0000;
          if (press[3] && !lock_ff) state_ff <= S_HOLD;
        end
        S_HOLD, S_ADDR_HELD: begin
          if (!stable_ff[3]) begin
            state_ff  <= (state_ff == S_HOLD) ? S_IDLE : S_ADDR_TAP;
            seq_ms_ff <= 14'h0000;
            taps_ff   <= 2'h0;
          end else if (tick) begin
            seq_ms_ff <= seq_ms_ff + 14'h0001;
            if (state_ff == S_HOLD && seq_ms_ff == 14'(ADDR_HOLD_MS - 1)) state_ff <= S_ADDR_HELD;
            if (state_ff == S_ADDR_HELD && seq_ms_ff == 14'(RESET_HOLD_MS - 1)) state_ff <= S_RST_HELD;
          end
        end
        S_RST_HELD: begin
          seq_ms_ff <= 14'h0000;
          taps_ff   <= 2'h0;
          if (!stable_ff[3]) state_ff <= S_RST_TAP;
        end
        S_ADDR_TAP, S_RST_TAP: begin
          if (tap_done || timeout) state_ff <= S_IDLE;
          else begin
            if (press[3]) taps_ff <= taps_ff + 2'h1;
            if (tick) seq_ms_ff <= seq_ms_ff + 14'h0001;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Lock pairing and button actions
  // ****************************************
  logic       pend0_ff, pend3_ff, pair_hit, expire;
  logic [6:0] pair_ms_ff;
  logic [3:0] act;
  logic       audio_press;
  assign audio_press = press[3] && !tap_state;
  assign pair_hit = (press[0] && (pend3_ff || audio_press)) || (audio_press && pend0_ff);
  assign expire   = (pend0_ff || pend3_ff) && tick && (pair_ms_ff == 7'(LOCK_WIN_MS - 1));
  assign act      = {expire && pend3_ff, press[2], press[1], expire && pend0_ff};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend0_ff   <= 1'b0;
      pend3_ff   <= 1'b0;
      pair_ms_ff <= 7'h00;
    end else if (clk_en) begin
      if (pair_hit || expire) begin
        pend0_ff <= 1'b0;
        pend3_ff <= 1'b0;
      end else if (press[0] || audio_press) begin
        pend0_ff   <= pend0_ff | press[0];
        pend3_ff   <= pend3_ff | audio_press;
        pair_ms_ff <= 7'h00;
      end else if (tick) pair_ms_ff <= pair_ms_ff + 7'h01;
    end
  end

  // ****************************************
  // Bus slave state
  // ****************************************
  logic       wr_pend_ff;
  logic [3:0] wr_addr_ff;
  logic       wr_ctrl, wr_sel, wr_event;
  logic [2:0] event_ff;
  logic       lights_off_ff, dhcp_ff;
  logic [SEL_W-1:0] sel_ff [4];
  assign wr_ctrl  = clk_en && wr_pend_ff && (wr_addr_ff == ADDR_CTRL);
  assign wr_sel   = clk_en && wr_pend_ff && (wr_addr_ff == ADDR_SEL);
  assign wr_event = clk_en && wr_pend_ff && (wr_addr_ff == ADDR_EVENT);

  // ****************************************
  // Control bits: lock, lights-off, addressing
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_ff       <= 1'b0;
      lights_off_ff <= 1'b0;
      dhcp_ff       <= CTRL_DHCP_RST;
    end else if (clk_en) begin
      if (factory_go) begin
        lock_ff       <= 1'b0;
        lights_off_ff <= 1'b0;
        dhcp_ff       <= CTRL_DHCP_RST;
      end else begin
        if (pair_hit) lock_ff <= !lock_ff;
        else if (wr_ctrl) lock_ff <= hwdata[CTRL_LOCK];
        if (wr_ctrl) lights_off_ff <= hwdata[CTRL_LIGHTS_OFF];
        if (dhcp_go) dhcp_ff <= 1'b1;
        else if (wr_ctrl) dhcp_ff <= hwdata[CTRL_DHCP];
      end
    end
  end

  // ****************************************
  // Crosspoint selection
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) sel_ff[i] <= '0;
    end else if (clk_en) begin
      if (factory_go) begin
        for (int i = 0; i < 4; i++) sel_ff[i] <= '0;
      end else if (!lock_ff) begin
        if (TWO_INPUT) begin
          if (act[0]) sel_ff[0] <= SEL_W'(0);
          else if (act[1]) sel_ff[0] <= SEL_W'(1);
          if (act[3]) sel_ff[3] <= adv(sel_ff[3]);
        end else begin
          for (int i = 0; i < 4; i++)
            if (act[i]) sel_ff[i] <= adv(sel_ff[i]);
        end
      end
      if (!lock_ff && (act == 4'h0) && wr_sel) begin
        for (int i = 0; i < 4; i++) sel_ff[i] <= hwdata[i*SEL_W +: SEL_W];
      end
    end
  end
  assign sel_out_one   = sel_ff[0];
  assign sel_out_two   = sel_ff[1];
  assign sel_out_three = sel_ff[2];
  assign audio_src     = sel_ff[3];
  assign dhcp_enable   = dhcp_ff;

  // ****************************************
  // Feedback blink engine
  // ****************************************
  logic [3:0] bl_left_ff;
  logic [9:0] bl_half_ff, bl_ms_ff, sq_ms_ff;
  logic       bl_lit_ff, sq_lit_ff, reboot_ff, locked_press;
  assign locked_press = lock_ff && !pair_hit && (act != 4'h0);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bl_left_ff <= 4'h0;
      bl_half_ff <= 10'h000;
      bl_ms_ff   <= 10'h000;
      bl_lit_ff  <= 1'b0;
    end else if (clk_en) begin
      bl_ms_ff <= 10'h000;
      if (dhcp_go || factory_go) begin
        bl_left_ff <= 4'h1;
        bl_half_ff <= 10'(DARK_MS);
        bl_lit_ff  <= 1'b0;
      end else if (pair_hit) begin
        bl_left_ff <= 4'(2 * LOCK_BLINKS);
        bl_half_ff <= 10'(BLINK_HALF_MS);
        bl_lit_ff  <= 1'b1;
      end else if (locked_press) begin
        bl_left_ff <= 4'(2 * LOCKED_BLINKS);
        bl_half_ff <= 10'(QUICK_HALF_MS);
        bl_lit_ff  <= 1'b1;
      end else if (bl_left_ff != 4'h0) begin
        bl_ms_ff <= bl_ms_ff;
        if (tick) begin
          if (bl_ms_ff == bl_half_ff - 10'h001) begin
            bl_left_ff <= bl_left_ff - 4'h1;
            bl_lit_ff  <= !bl_lit_ff;
            bl_ms_ff   <= 10'h000;
          end else bl_ms_ff <= bl_ms_ff + 10'h001;
        end
      end
    end
  end
  // Continuous blink during the hold sequence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sq_ms_ff  <= 10'h000;
      sq_lit_ff <= 1'b0;
    end else if (clk_en) begin
      if (!seq_blink) begin
        sq_ms_ff  <= 10'h000;
        sq_lit_ff <= 1'b1;
      end else if (tick) begin
        if (sq_ms_ff >= (seq_fast ? 10'(FAST_HALF_MS - 1) : 10'(SLOW_HALF_MS - 1))) begin
          sq_ms_ff  <= 10'h000;
          sq_lit_ff <= !sq_lit_ff;
        end else sq_ms_ff <= sq_ms_ff + 10'h001;
      end
    end
  end

  // ****************************************
  // Port status blink and reboot
  // ****************************************
  logic [3:0] pb_ff;
  logic [8:0] pb_ms_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pb_ff    <= 4'h0;
      pb_ms_ff <= 9'h000;
      reboot_ff <= 1'b0;
    end else if (clk_en) begin
      reboot_ff <= factory_go;
      if (!lock_ff && (act != 4'h0)) begin
        pb_ff    <= act;
        pb_ms_ff <= 9'h000;
      end else if (tick && pb_ff != 4'h0) begin
        if (pb_ms_ff == 9'(PORT_BLINK_MS - 1)) pb_ff <= 4'h0;
        else pb_ms_ff <= pb_ms_ff + 9'h001;
      end
    end
  end
  assign reboot_req      = reboot_ff;
  assign front_led_force = lights_off_ff || seq_blink || (bl_left_ff != 4'h0);
  assign front_led_lit   = !lights_off_ff && (seq_blink ? sq_lit_ff : (bl_left_ff != 4'h0) && bl_lit_ff);
  assign port_led_blink  = lights_off_ff ? 4'h0 : pb_ff;

  // ****************************************
  // AHB-Lite register access
  // ****************************************
  logic [31:0] rdata_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 4'h0;
      rdata_ff   <= 32'h0000_0000;
    end else if (clk_en) begin
      wr_pend_ff <= 1'b0;
      if (hready && hsel && htrans == HTRANS_NONSEQ) begin
        wr_pend_ff <= hwrite && (haddr[31:4] == 28'h0000000);
        wr_addr_ff <= haddr[3:0];
        rdata_ff   <= 32'h0000_0000;
        if (!hwrite && haddr[31:4] == 28'h0000000) begin
          case (haddr[3:0])
            ADDR_CTRL:   rdata_ff <= {29'h0, lock_ff, dhcp_ff, lights_off_ff};
            ADDR_SEL:    rdata_ff <= {24'h0, sel_ff[3], sel_ff[2], sel_ff[1], sel_ff[0]};
            ADDR_STATUS: rdata_ff <= {16'h0, 5'h0, state_ff, taps_ff, 2'h0, stable_ff};
            ADDR_EVENT:  rdata_ff <= {29'h0, event_ff};
            default:     rdata_ff <= 32'h0000_0000;
          endcase
        end
      end
    end
  end
  // Sticky events, write one to clear; a new event wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) event_ff <= 3'h0;
    else if (clk_en) event_ff <= (event_ff & ~(wr_event ? hwdata[2:0] : 3'h0)) | {pair_hit, factory_go, dhcp_go};
  end
  assign hreadyout = clk_en;
  assign hrdata    = rdata_ff;
  assign hresp     = 1'b0;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_lock_toggle: assert property (clk_en && pair_hit && !factory_go |=> lock_ff != $past(lock_ff))
    else $error("lock did not toggle");
  a_lock_blink: assert property (clk_en && pair_hit && !tap_done |=> bl_left_ff == 4'h8 && bl_lit_ff)
    else $error("lock confirm blink wrong");
  a_locked_hold: assert property (clk_en && lock_ff && act[1] && !factory_go |=> $stable(sel_out_two))
    else $error("locked press switched");
  a_locked_blink: assert property (clk_en && locked_press && !pair_hit && !tap_done |=> bl_left_ff == 4'h6)
    else $error("locked press blink wrong");
  a_addr_stage: assert property (clk_en && state_ff == S_HOLD && stable_ff[3] && tick
    && seq_ms_ff == 14'(ADDR_HOLD_MS - 1) |=> state_ff == S_ADDR_HELD && seq_blink)
    else $error("no blink at hold stage");
  a_dhcp_enable: assert property (clk_en && dhcp_go |=> dhcp_enable && front_led_force && !front_led_lit)
    else $error("addressing not enabled");
  a_fast_stage: assert property (clk_en && state_ff == S_ADDR_HELD && stable_ff[3] && tick
    && seq_ms_ff == 14'(RESET_HOLD_MS - 1) |=> state_ff == S_RST_HELD)
    else $error("no fast stage");
  a_factory_reset: assert property (clk_en && factory_go |=> dhcp_enable && audio_src == '0 && reboot_req)
    else $error("factory reset incomplete");
  a_dark_mode: assert property (lights_off_ff |-> !front_led_lit && port_led_blink == 4'h0)
    else $error("LED lit in lights-off");
  a_abandon_seq: assert property (clk_en && timeout |=> state_ff == S_IDLE && $stable(dhcp_enable))
    else $error("sequence not abandoned");
  a_step_wrap: assert property (clk_en && !TWO_INPUT && act[2] && !lock_ff && !factory_go
    && sel_ff[2] == SEL_W'(NUM_INPUTS - 1) |=> sel_out_three == '0)
    else $error("selection did not wrap");
  c_lock: cover property (clk_en && pair_hit);
  c_dhcp: cover property (clk_en && dhcp_go);
  c_factory: cover property (clk_en && factory_go);
  c_timeout: cover property (clk_en && timeout);
endmodule // front_panel_button_sequencer
`default_nettype wire

// File: tb/panel_operator.sv
`default_nettype none
module panel_operator #(
  parameter int TICK = 4
) (
  // Clock
  input  wire logic       hclk,
  // Panel buttons
  output var  logic [3:0] btn_raw
);
  timeunit 1ns;
  timeprecision 1ps;

  initial btn_raw = 4'h0;

  // Hold a set of buttons, then leave them released
  task automatic press(input logic [3:0] m, input int hi_ms, input int lo_ms);
    btn_raw <= m;
    repeat (hi_ms * TICK) @(posedge hclk);
    btn_raw <= 4'h0; // Released buttons fall to the pull-down level
    repeat (lo_ms * TICK) @(posedge hclk);
  endtask
endmodule // panel_operator
`default_nettype wire

// File: tb/front_panel_button_sequencer_tb.sv
`default_nettype none
module front_panel_button_sequencer_tb;
  import panel_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 2;
  typedef struct packed {logic [3:0] btn; logic [7:0] sel;} row_t;
  // ****************************************
  // Signals
  // ****************************************
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp, reboot_req, dhcp_enable;
  logic [1:0] htrans = 2'h0, sel_out_one, sel_out_two, sel_out_three, audio_src;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [3:0] btn_raw, port_led_blink;
  logic front_led_force, front_led_lit;
  int bad_count = 0, samples_checked = 0;
  row_t rows [8] = '{'{4'h2, 8'h04}, '{4'h2, 8'h08}, '{4'h2, 8'h0c}, '{4'h2, 8'h00},
                     '{4'h4, 8'h10}, '{4'h1, 8'h11}, '{4'h8, 8'h51}, '{4'h8, 8'h91}};
  always #20 hclk = ~hclk;
  // ****************************************
  // Design and operator
  // ****************************************
  front_panel_button_sequencer #(.TICK_CYCLES(TK)) uut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .btn_raw(btn_raw),
    .sel_out_one(sel_out_one), .sel_out_two(sel_out_two), .sel_out_three(sel_out_three),
    .audio_src(audio_src), .dhcp_enable(dhcp_enable), .reboot_req(reboot_req),
    .front_led_force(front_led_force), .front_led_lit(front_led_lit), .port_led_blink(port_led_blink));
  panel_operator #(.TICK(TK)) op (.hclk(hclk), .btn_raw(btn_raw));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim();
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Compare seen against expected
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Wait for hready at a rising edge, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      end_sim();
    end
  endtask
  // Single AHB-Lite word transfer
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  function automatic logic [7:0] sels();
    return {audio_src, sel_out_three, sel_out_two, sel_out_one};
  endfunction
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("dhcp_rst", dhcp_enable, 32'h1);
    bus(1'b0, 32'h0, 32'h0);
    check("ctrl_rst", rd, 32'h2);
    // Ordinary selection steps
    foreach (rows[i]) begin
      op.press(rows[i].btn, 30, 120);
      check("port_blink", port_led_blink & rows[i].btn, rows[i].btn);
      repeat (250 * TK) @(posedge hclk);
      check("sel", sels(), rows[i].sel);
    end
    bus(1'b0, 32'h4, 32'h0);
    check("sel_reg", rd, 32'h91);
    bus(1'b0, 32'h10, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("test selection done");
    // Lock, locked press, unlock
    op.press(4'h9, 30, 120);
    check("lock_led", {front_led_force, front_led_lit}, 32'h3);
    repeat (2200 * TK) @(posedge hclk);
    bus(1'b0, 32'h0, 32'h0);
    check("locked", rd[CTRL_LOCK], 32'h1);
    op.press(4'h2, 30, 60);
    check("locked_blink", front_led_force, 32'h1);
    repeat (500 * TK) @(posedge hclk);
    check("locked_sel", sels(), 32'h91);
    op.press(4'h9, 30, 2300);
    bus(1'b0, 32'h0, 32'h0);
    check("unlocked", rd[CTRL_LOCK], 32'h0);
    $display("test lock done");
    // Lights-off keeps LEDs dark while selection works
    bus(1'b1, 32'h0, 32'h3);
    op.press(4'h2, 30, 120);
    check("dark_port", port_led_blink, 32'h0);
    check("dark_front", front_led_lit, 32'h0);
    repeat (250 * TK) @(posedge hclk);
    check("dark_sel", sel_out_two, 32'h1);
    $display("test lights_off done");
    // Long hold, triple tap, factory defaults
    bus(1'b1, 32'h0, 32'h0);
    fork
      op.press(4'h8, 10100, 200);
      begin
        repeat (6000 * TK) @(posedge hclk);
        check("slow_blink", front_led_force, 32'h1);
        bus(1'b0, 32'h8, 32'h0);
        check("slow_state", rd[10:8], 32'h2);
        repeat (4050 * TK) @(posedge hclk);
        check("fast_blink", front_led_force, 32'h1);
        bus(1'b0, 32'h8, 32'h0);
        check("fast_state", rd[10:8], 32'h3);
      end
    join
    repeat (2) op.press(4'h8, 40, 60);
    fork
      op.press(4'h8, 40, 0);
      begin : wait_reboot
        int n;
        for (n = 0; n < 4000 && reboot_req !== 1'b1; n++) @(posedge hclk);
        check("reboot", reboot_req, 32'h1);
      end
    join
    @(posedge hclk);
    check("dhcp_def", dhcp_enable, 32'h1);
    check("sel_def", sels(), 32'h0);
    check("dark_after", front_led_lit, 32'h0);
    $display("test factory done");
    // Missed triple window leaves addressing off
    bus(1'b1, 32'h0, 32'h0);
    op.press(4'h8, 5100, 100);
    op.press(4'h8, 40, 3100);
    bus(1'b0, 32'h8, 32'h0);
    check("abandon_state", rd[10:8], 32'h0);
    check("abandon_dhcp", dhcp_enable, 32'h0);
    check("abandon_led", front_led_force, 32'h0);
    $display("test abandon done");
    // Release at the first stage, three taps enable addressing
    op.press(4'h8, 5100, 100);
    repeat (3) op.press(4'h8, 40, 60);
    check("dhcp_on", dhcp_enable, 32'h1);
    check("dhcp_dark", {front_led_force, front_led_lit}, 32'h2);
    $display("test dhcp done");
    end_sim();
  end
  // Overall hang guard
  initial begin
    repeat (95000) @(posedge hclk);
    bad_count++;
    end_sim();
  end
endmodule // front_panel_button_sequencer_tb
`default_nettype wire
